// ### indicator_privacy_adc_config.sv
`timescale 1ns/1ps
module indicator_privacy_adc_config
  import indicator_cfg_pkg::*;
#(
  parameter int STEP_CYCLES = DELAY_STEP_CYCLES,  // Cycles per 250 us delay step
  parameter int TICK_CNT    = TICK_CYCLES          // Cycles per 32 us timebase tick
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  // Converter handshake
  input  wire logic              conv_complete,
  output logic                   conv_start,
  // Flash and privacy requests
  input  wire logic              privacy_req,
  input  wire logic              flash_active,
  output logic                   first_current_source,
  output logic                   second_current_source,
  output logic      [2:0]        privacy_duty_code,
  // Monitor and indicator configuration
  output supply_cfg_t            supply_cfg,
  output msg_cfg_t               msg_cfg
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Refused while elaborating: the counters below are sized for these ranges
  if (STEP_CYCLES < 1 || STEP_CYCLES >= 2**18) begin : g_bad_step
    $error("STEP_CYCLES out of range");
  end
  if (TICK_CNT < 1 || TICK_CNT >= 2**16) begin : g_bad_tick
    $error("TICK_CNT out of range");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address match, used by both write and read decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Period shift: period in ticks is PWM_MIN_TICKS shifted left by this
  function automatic logic [2:0] pwm_shift(input logic [2:0] code);
    pwm_shift = code[2] ? 3'h0 : (3'h4 - {1'b0, code[1:0]});
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  start_delay_ff;   // conversion_start_delay
  logic [7:0]  supply_ff;        // supply_monitor_control
  logic [7:0]  privacy_ff;       // privacy_indicator_control
  logic [7:0]  pwm_period_ff;    // privacy_pwm_period_select
  logic [7:0]  message_ff;       // message_indicator_control
  logic        conv_done_ff;     // Conversion-done flag
  conv_state_t conv_state_ff;    // Delay sequencer, also read back as status
  logic [7:0]  rd_data_ff;       // Read data, one cycle after strobe
  logic [7:0]  nxt_rd_data;      // Read mux

  // Software writes, unused bits masked away
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_delay_ff <= RST_START_DELAY;
      supply_ff      <= RST_SUPPLY;
      privacy_ff     <= RST_PRIVACY;
      pwm_period_ff  <= RST_PWM;
      message_ff     <= RST_MESSAGE;
    end else if (wr_en) begin
      if (hit(addr, OFS_START_DELAY)) begin
        start_delay_ff <= wr_data & MASK_START_DELAY;
      end
      if (hit(addr, OFS_SUPPLY)) begin
        supply_ff <= wr_data & MASK_SUPPLY;
      end
      if (hit(addr, OFS_PRIVACY)) begin
        privacy_ff <= wr_data & MASK_PRIVACY;
      end
      if (hit(addr, OFS_PWM)) begin
        pwm_period_ff <= wr_data & MASK_PWM;
      end
      if (hit(addr, OFS_MESSAGE)) begin
        message_ff <= wr_data & MASK_MESSAGE;
      end
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    nxt_rd_data = 8'h00;
    if (hit(addr, OFS_START_DELAY)) begin
      nxt_rd_data = start_delay_ff;
    end else if (hit(addr, OFS_SUPPLY)) begin
      nxt_rd_data = supply_ff;
    end else if (hit(addr, OFS_PRIVACY)) begin
      nxt_rd_data = privacy_ff;
    end else if (hit(addr, OFS_PWM)) begin
      nxt_rd_data = pwm_period_ff;
    end else if (hit(addr, OFS_MESSAGE)) begin
      nxt_rd_data = message_ff;
    end else if (hit(addr, OFS_STATUS)) begin
      nxt_rd_data[STAT_DONE_BIT] = conv_done_ff;
      nxt_rd_data[STAT_WAIT_BIT] = (conv_state_ff == CS_WAIT);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_ff <= 8'h00;
    end else if (rd_en) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Conversion-done flag and start delay
  // ----------------------------------------------------------------
  logic [17:0] step_cyc_ff;     // Cycles within one 250 us step
  logic [4:0]  steps_left_ff;   // Whole steps still to wait
  logic        conv_start_ff;   // One-cycle start pulse
  logic        done_clear;      // Software clears the flag

  assign done_clear = wr_en && hit(addr, OFS_STATUS) && wr_data[STAT_DONE_BIT];

  // Completion sets, software clears; a completion in the clear cycle wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conv_done_ff <= 1'b0;
    end else if (conv_complete) begin
      conv_done_ff <= 1'b1;
    end else if (done_clear) begin
      conv_done_ff <= 1'b0;
    end
  end

  // The delay runs from the flag's falling edge; the mode of the converter
  // is not looked at, so manual and automatic runs share one timing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conv_state_ff <= CS_IDLE;
      step_cyc_ff   <= 18'h00000;
      steps_left_ff <= 5'h00;
      conv_start_ff <= 1'b0;
    end else begin
      conv_start_ff <= 1'b0;
      case (conv_state_ff)
        CS_IDLE: begin
          if (conv_done_ff && done_clear && !conv_complete) begin
            step_cyc_ff   <= 18'h00000;
            steps_left_ff <= start_delay_ff[4:0];
            if (start_delay_ff[NO_DELAY_BIT]) begin
              conv_state_ff <= CS_START;
            end else begin
              conv_state_ff <= CS_WAIT;
            end
          end
        end
        CS_WAIT: begin
          // A fresh completion aborts a wait that is no longer needed
          if (conv_complete) begin
            conv_state_ff <= CS_IDLE;
          end else if (step_cyc_ff == 18'(STEP_CYCLES - 1)) begin
            step_cyc_ff <= 18'h00000;
            if (steps_left_ff == 5'h00) begin
              conv_state_ff <= CS_START;
            end else begin
              steps_left_ff <= steps_left_ff - 5'h01;
            end
          end else begin
            step_cyc_ff <= step_cyc_ff + 18'h00001;
          end
        end
        CS_START: begin
          conv_start_ff <= 1'b1;
          conv_state_ff <= CS_IDLE;
        end
        default: begin
          conv_state_ff <= CS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Timebase: one-cycle tick every 32 us
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_ff;  // Prescaler
  logic        tick_ff;      // Tick enable

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 16'(TICK_CNT - 1)) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      tick_ff     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Privacy sequencing around the flash pulse
  // ----------------------------------------------------------------
  priv_state_t priv_state_ff;  // Privacy indicator state

  // Flash pre-empts privacy; afterwards the terminate bit decides
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      priv_state_ff <= PS_OFF;
    end else begin
      case (priv_state_ff)
        PS_OFF: begin
          if (privacy_req) begin
            priv_state_ff <= flash_active ? PS_FLASH : PS_ON;
          end
        end
        PS_ON: begin
          if (!privacy_req) begin
            priv_state_ff <= PS_OFF;
          end else if (flash_active) begin
            priv_state_ff <= PS_FLASH;
          end
        end
        PS_FLASH: begin
          if (!privacy_req) begin
            priv_state_ff <= PS_OFF;
          end else if (!flash_active) begin
            priv_state_ff <= privacy_ff[PRIV_TERM_BIT] ? PS_HELD : PS_ON;
          end
        end
        PS_HELD: begin
          // Stays dark until the request is dropped and raised again
          if (!privacy_req) begin
            priv_state_ff <= PS_OFF;
          end
        end
        default: begin
          priv_state_ff <= PS_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Privacy PWM and blink
  // ----------------------------------------------------------------
  logic [7:0]  pwm_cnt_ff;     // Ticks within the PWM period
  logic [15:0] blink_cnt_ff;   // Ticks within the blink period
  logic [7:0]  period_ticks;   // Current PWM period in ticks
  logic [7:0]  on_ticks;       // Ticks the source is on per period
  logic [15:0] blink_ticks;    // Current blink period in ticks
  logic        blink_on;       // High in first half of blink period
  logic        pwm_on;         // High in duty part of PWM period
  logic        src1_ff;        // First source drive
  logic        src2_ff;        // Second source drive

  // Period shrinks by halves from 160 ticks to 10 ticks
  assign period_ticks = 8'(PWM_MIN_TICKS) << pwm_shift(pwm_period_ff[2:0]);
  // Each tenth of a period is one shifted tick
  assign on_ticks = ({5'h00, privacy_ff[2:0]} + 8'h01)
                    << pwm_shift(pwm_period_ff[2:0]);
  assign pwm_on = (pwm_cnt_ff < on_ticks);
  // Blink period doubles per code above one; the source is lit for half
  assign blink_ticks = 16'(BLINK_BASE_TICKS) << (privacy_ff[7:6] - 2'h1);
  assign blink_on = (privacy_ff[7:6] == 2'h0) ||
                    (blink_cnt_ff < (blink_ticks >> 1));

  // Period counters, held at zero outside PS_ON; a code change takes effect at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwm_cnt_ff   <= 8'h00;
      blink_cnt_ff <= 16'h0000;
    end else if (priv_state_ff != PS_ON) begin
      pwm_cnt_ff   <= 8'h00;
      blink_cnt_ff <= 16'h0000;
    end else if (tick_ff) begin
      if (pwm_cnt_ff >= period_ticks - 8'h01) begin
        pwm_cnt_ff <= 8'h00;
      end else begin
        pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
      end
      if (blink_cnt_ff >= blink_ticks - 16'h0001) begin
        blink_cnt_ff <= 16'h0000;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + 16'h0001;
      end
    end
  end

  // Source drives; PWM resolution is one 32 us tick
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      src1_ff <= 1'b0;
      src2_ff <= 1'b0;
    end else begin
      src1_ff <= (priv_state_ff == PS_ON) && pwm_on && blink_on &&
                 privacy_ff[PRIV_SRC1_BIT];
      src2_ff <= (priv_state_ff == PS_ON) && pwm_on && blink_on &&
                 privacy_ff[PRIV_SRC2_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data               = rd_data_ff;
  assign conv_start            = conv_start_ff;
  assign first_current_source  = src1_ff;
  assign second_current_source = src2_ff;
  assign privacy_duty_code     = privacy_ff[2:0];
  assign supply_cfg            = supply_ff[5:0];
  assign msg_cfg               = message_ff;

endmodule

// ### indicator_cfg_pkg.sv
package indicator_cfg_pkg;

  // ----------------------------------------------------------------
  // Register bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_START_DELAY = 8'h00;  // conversion_start_delay
  localparam logic [7:0] OFS_SUPPLY      = 8'h01;  // supply_monitor_control
  localparam logic [7:0] OFS_PRIVACY     = 8'h02;  // privacy_indicator_control
  localparam logic [7:0] OFS_PWM         = 8'h03;  // privacy_pwm_period_select
  localparam logic [7:0] OFS_MESSAGE     = 8'h04;  // message_indicator_control
  localparam logic [7:0] OFS_STATUS      = 8'h05;  // conversion status

  // ----------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_START_DELAY  = 8'h00;
  localparam logic [7:0] RST_SUPPLY       = 8'h00;
  localparam logic [7:0] RST_PRIVACY      = 8'h58;  // Blink 128 ms, first source, terminate
  localparam logic [7:0] RST_PWM          = 8'h00;
  localparam logic [7:0] RST_MESSAGE      = 8'h00;
  localparam logic [7:0] MASK_START_DELAY = 8'h3f;
  localparam logic [7:0] MASK_SUPPLY      = 8'h3f;
  localparam logic [7:0] MASK_PRIVACY     = 8'hff;
  localparam logic [7:0] MASK_PWM         = 8'h07;
  localparam logic [7:0] MASK_MESSAGE     = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NO_DELAY_BIT   = 5;
  localparam int PRIV_SRC1_BIT  = 4;
  localparam int PRIV_SRC2_BIT  = 5;
  localparam int PRIV_TERM_BIT  = 3;
  localparam int PRIV_BLINK_LSB = 6;
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_WAIT_BIT  = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 25_000_000;
  localparam int DELAY_STEP_US     = 250;
  localparam int DELAY_STEP_CYCLES = DELAY_STEP_US * (CLK_HZ / 1_000_000);
  localparam int TICK_US           = 32;
  localparam int TICK_CYCLES       = TICK_US * (CLK_HZ / 1_000_000);
  localparam int PWM_MIN_US        = 320;
  localparam int PWM_MIN_TICKS     = PWM_MIN_US / TICK_US;
  localparam int DUTY_STEPS        = 10;
  localparam int BLINK_BASE_MS     = 128;
  localparam int BLINK_BASE_TICKS  = BLINK_BASE_MS * 1000 / TICK_US;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] flash_thr;  // 00=2.9 V ... 11=3.2 V
    logic       flash_en;
    logic [1:0] thr;
    logic       en;
  } supply_cfg_t;

  typedef struct packed {
    logic [1:0] ramp_time;        // 78/156/312/624 ms
    logic [2:0] pulse_count;
    logic [2:0] indicator_level;  // 2.25 mA steps
  } msg_cfg_t;

  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_WAIT  = 2'b01,
    CS_START = 2'b10
  } conv_state_t;

  typedef enum logic [1:0] {
    PS_OFF   = 2'b00,
    PS_ON    = 2'b01,
    PS_FLASH = 2'b10,
    PS_HELD  = 2'b11
  } priv_state_t;

endpackage

// ### indicator_privacy_adc_config_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module indicator_privacy_adc_config_monitor
  import indicator_cfg_pkg::*;
#(
  parameter int STEP_CYCLES = 4,  // Cycles per delay step
  parameter int TICK_CNT    = 2   // Cycles per timebase tick
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  // Converter handshake
  input wire logic              conv_complete,
  input wire logic              conv_start,
  // Privacy
  input wire logic              privacy_req,
  input wire logic              flash_active,
  input wire logic              first_current_source,
  input wire logic              second_current_source,
  input wire logic [2:0]        privacy_duty_code,
  // Configuration outputs
  input wire supply_cfg_t       supply_cfg,
  input wire msg_cfg_t          msg_cfg
);
  // One clock domain, so one clocking and one disable for all
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Read data must stay quiet outside the answer cycle
  a_rd_idle_zero: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rd_en && addr > OFS_STATUS |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  // Writes land in the exported fields the next cycle; supply reads back
  a_supply_write: assert property (wr_en && addr == OFS_SUPPLY
    |=> {2'b00, supply_cfg} == ($past(wr_data) & MASK_SUPPLY)) else $error("supply write lost");
  a_msg_write: assert property (wr_en && addr == OFS_MESSAGE
    |=> msg_cfg == $past(wr_data)) else $error("message write lost");
  a_duty_write: assert property (wr_en && addr == OFS_PRIVACY
    |=> {5'h00, privacy_duty_code} == ($past(wr_data) & 8'h07)) else $error("duty write lost");
  a_supply_read: assert property (rd_en && addr == OFS_SUPPLY
    |=> rd_data == {2'b00, $past(supply_cfg)}) else $error("supply readback wrong");
  // A start is a single pulse
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  // Sources dark during flash and when not requested
  a_flash_dark: assert property (flash_active [*3]
    |-> !first_current_source && !second_current_source) else $error("source lit in flash");
  a_idle_dark: assert property (!privacy_req [*3]
    |-> !first_current_source && !second_current_source) else $error("source lit when idle");
endmodule

// ### indicator_privacy_adc_config_tb.sv
`timescale 1ns/1ps
module indicator_privacy_adc_config_tb;
  import indicator_cfg_pkg::*;
  // ----------------------------------------------------------------
  // Shortened counts keep the run brief
  // ----------------------------------------------------------------
  localparam int STEP = 4;
  localparam int TICK = 2;
  localparam logic [7:0] OFS_T [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
  localparam logic [7:0] RST_T [5] = '{8'h00, 8'h00, 8'h58, 8'h00, 8'h00};
  localparam logic [7:0] MSK_T [5] = '{8'h3f, 8'h3f, 8'hff, 8'h07, 8'hff};
  localparam logic [7:0] PCODE [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07};
  localparam int         PRISE [6] = '{2, 4, 8, 16, 32, 32};
  logic        clk, rst_b, wr_en, rd_en, conv_complete, conv_start;
  logic        privacy_req, flash_active, src1, src2, prev;
  logic [7:0]  addr, wr_data, rd_data;
  logic [2:0]  duty_code;
  supply_cfg_t supply_cfg;
  msg_cfg_t    msg_cfg;
  int          bad_count, cmp_count, hi1, hi2, rises, n;

  // Clock: 40 ns period
  always #20 clk = ~clk;

  indicator_privacy_adc_config #(.STEP_CYCLES(STEP), .TICK_CNT(TICK)) DUT (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .conv_complete(conv_complete),
    .conv_start(conv_start), .privacy_req(privacy_req), .flash_active(flash_active),
    .first_current_source(src1), .second_current_source(src2),
    .privacy_duty_code(duty_code), .supply_cfg(supply_cfg), .msg_cfg(msg_cfg));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Timing counts wobble with phase, so accept a tolerance
  function automatic logic [15:0] near(input int v, input int e, input int tol);
    return (v >= e - tol && v <= e + tol) ? 16'(e) : 16'(v);
  endfunction
  // Extra idle edge at the end avoids a double strobe assignment
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({8'h00, rd_data}, {8'h00, exp});
  endtask
  // Settle, then count lit cycles and rising edges
  task meas(input int settle, input int cyc);
    repeat (settle) @(posedge clk);
    hi1 = 0;
    hi2 = 0;
    rises = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      hi1 += (src1 === 1'b1);
      hi2 += (src2 === 1'b1);
      rises += (src1 === 1'b1 && prev === 1'b0);
      prev = src1;
    end
  endtask
  // Done flag set, cleared by software, then time the start
  task conv(input logic [7:0] code, input int exp, input int tol);
    wr(OFS_START_DELAY, code);
    conv_complete <= 1'b1;
    @(posedge clk);
    conv_complete <= 1'b0;
    @(posedge clk);
    rd(OFS_STATUS, 8'h01);
    addr <= OFS_STATUS;
    wr_data <= 8'h01;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    n = 0;
    while (conv_start !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(near(n, exp, tol), 16'(exp));
  endtask
  task final_report;
    $display("mismatches %0d, comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; rst_b = 0; addr = 0; wr_data = 0; wr_en = 0; rd_en = 0;
    conv_complete = 0; privacy_req = 0; flash_active = 0; prev = 0;
    bad_count = 0; cmp_count = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Reset values, then all ones to expose unused bits
    for (int i = 0; i < 5; i++) begin
      rd(OFS_T[i], RST_T[i]);
      wr(OFS_T[i], 8'hff);
      rd(OFS_T[i], MSK_T[i]);
    end
    rd(OFS_STATUS, 8'h00);
    rd(8'h9c, 8'h00);
    wr(OFS_SUPPLY, 8'hd2);
    rd(OFS_SUPPLY, 8'h12);
    chk({10'h000, supply_cfg}, 16'h0012);
    wr(OFS_MESSAGE, 8'h9e);
    chk({8'h00, msg_cfg}, 16'h009e);
    // Start delay: shortest, longest, no-delay, unused bits set
    conv(8'h00, STEP + 1, 0);
    conv(8'h1f, 32 * STEP + 1, 0);
    conv(8'h3f, 1, 0);
    conv(8'hc5, 6 * STEP + 1, 0);
    // A new completion during the wait cancels the start
    conv_complete <= 1'b1;
    @(posedge clk);
    conv_complete <= 1'b0;
    wr(OFS_STATUS, 8'h01);
    repeat (10) @(posedge clk);
    rd(OFS_STATUS, 8'h02);
    conv_complete <= 1'b1;
    @(posedge clk);
    conv_complete <= 1'b0;
    n = 0;
    repeat (200) begin
      @(posedge clk);
      #1;
      n += (conv_start === 1'b1);
    end
    chk(16'(n), 16'h0000);
    // Every duty code, both sources, 320 us period
    wr(OFS_PWM, 8'h04);
    privacy_req <= 1'b1;
    for (int d = 0; d < 8; d++) begin
      wr(OFS_PRIVACY, 8'h30 + 8'(d));
      meas(40, 640);
      chk(near(hi1, 64 * (d + 1), 4), 16'(64 * (d + 1)));
      chk(near(hi2, 64 * (d + 1), 4), 16'(64 * (d + 1)));
    end
    // Period codes, first source only
    wr(OFS_PRIVACY, 8'h10);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_PWM, PCODE[i]);
      meas(400, 640);
      chk(near(rises, PRISE[i], 1), 16'(PRISE[i]));
      chk(16'(hi2), 16'h0000);
    end
    // Flash with terminate set: stays dark afterwards
    wr(OFS_PWM, 8'h04);
    wr(OFS_PRIVACY, 8'h1f);
    flash_active <= 1'b1;
    meas(4, 40);
    chk(16'(hi1), 16'h0000);
    flash_active <= 1'b0;
    meas(4, 100);
    chk(16'(hi1), 16'h0000);
    privacy_req <= 1'b0;
    // Terminate clear: indication resumes after the flash
    wr(OFS_PRIVACY, 8'h17);
    privacy_req <= 1'b1;
    flash_active <= 1'b1;
    meas(4, 40);
    chk(16'(hi1), 16'h0000);
    flash_active <= 1'b0;
    meas(4, 100);
    chk(near(hi1, 80, 4), 16'd80);
    // Blink codes: lit half of each full blink period
    for (int b = 1; b < 4; b++) begin
      wr(OFS_PRIVACY, {2'(b), 6'h17});
      meas(4, 8000 << (b - 1));
      chk(near(hi1, 3200 << (b - 1), 40 << (b - 1)), 16'(3200 << (b - 1)));
    end
    privacy_req <= 1'b0;
    final_report();
  end
endmodule

bind indicator_privacy_adc_config indicator_privacy_adc_config_monitor #(
  .STEP_CYCLES(STEP_CYCLES), .TICK_CNT(TICK_CNT)) u_monitor (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .conv_complete(conv_complete),
  .conv_start(conv_start), .privacy_req(privacy_req), .flash_active(flash_active),
  .first_current_source(first_current_source),
  .second_current_source(second_current_source),
  .privacy_duty_code(privacy_duty_code), .supply_cfg(supply_cfg), .msg_cfg(msg_cfg));
